// ==== hdl/counter_flags.v ====
// Overview of operation
// - pending flag is high while a queued interrupt waits; hardware only.
// - one in service plus two queued; overrun sets the lost flag.
// - lost flag stays set until software writes it clear.
// - low mask zero blocks low preset interrupt; bidirectional modes only.
// - masks written only by software; retained, never changed by hardware.
// - low cause flag set when low preset interrupt is triggered.
// - low cause cleared by other interrupts, executing-mode entry, software.
// - while executing, low reached equals count at or below low preset.
// - high mask zero blocks high preset interrupt in every mode.
// - high cause flag set when high preset interrupt is triggered.
// - high cause cleared by other interrupts, executing-mode entry, software.
// - while executing, high reached equals count at or above high preset.
// - underflow flag set on downward pass through limit; software clears.
// - overflow flag set on upward pass through limit; software clears.
// - underflow and overflow never fault or stop operation.
// - underflow mask zero blocks underflow interrupt; bidirectional only.
// - underflow cause set when underflow interrupt is triggered.
// - underflow cause cleared by other interrupts, mode entry, software.
// - subroutine enable zero blocks every counter interrupt.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "counter_flags_defines.vh"

module counter_flags #(
   parameter CW = 32
) (
   input  wire                 mclk_i,
   input  wire                 rst_n_i,
   input  wire [7:0]           addr_i,
   input  wire [31:0]          wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [31:0]          rdata_o,
   input  wire [CW-1:0]        count_total_i,
   input  wire                 executing_i,
   input  wire                 bidir_mode_i,
   input  wire                 service_done_i,
   output wire                 service_active_o,
   output wire [1:0]           service_source_o,
   output wire                 interrupt_pending_flag_o,
   output wire                 interrupt_lost_flag_o
);

   // ------------------------------------------------------------
   // one-hot decode of a source code
   // ------------------------------------------------------------
   function [3:0] src_onehot;
      input [1:0] src;
      begin
         src_onehot = 4'h0;
         src_onehot[src] = 1'b1;
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [`CTL_WIDTH-1:0] ctl_reg;
   reg  [CW-1:0]         low_preset_value_reg;
   reg  [CW-1:0]         high_preset_value_reg;
   reg  [CW-1:0]         underflow_limit_reg;
   reg  [CW-1:0]         overflow_limit_reg;
   reg  [CW-1:0]         prev_count_reg;
   reg                   prev_valid_reg;
   reg                   executing_reg;
   reg                   interrupt_lost_flag_reg;
   reg                   low_preset_cause_flag_reg;
   reg                   low_preset_reached_flag_reg;
   reg                   high_preset_cause_flag_reg;
   reg                   high_preset_reached_flag_reg;
   reg                   underflow_event_flag_reg;
   reg                   underflow_cause_flag_reg;
   reg                   overflow_event_flag_reg;
   reg  [1:0]            q_reg [0:`QUEUE_SLOTS-1];
   reg  [1:0]            q_cnt_reg;
   reg  [1:0]            q_next [0:`QUEUE_SLOTS-1];
   reg  [1:0]            q_cnt_next;

   wire                  sub_en    = ctl_reg[`CTL_SUB_ENABLE];
   wire                  low_mask  = ctl_reg[`CTL_LOW_MASK];
   wire                  high_mask = ctl_reg[`CTL_HIGH_MASK];
   wire                  und_mask  = ctl_reg[`CTL_UNDER_MASK];

   wire                  wr_status = wr_i && (addr_i == `OFS_STATUS);

   // ------------------------------------------------------------
   // comparisons against the running count (signed)
   // ------------------------------------------------------------
   wire signed [CW-1:0]  cnt_s  = count_total_i;
   wire signed [CW-1:0]  prev_s = prev_count_reg;
   wire signed [CW-1:0]  lop_s  = low_preset_value_reg;
   wire signed [CW-1:0]  hip_s  = high_preset_value_reg;
   wire signed [CW-1:0]  unf_s  = underflow_limit_reg;
   wire signed [CW-1:0]  ovf_s  = overflow_limit_reg;

   wire  at_low   = (cnt_s <= lop_s);
   wire  at_high  = (cnt_s >= hip_s);
   wire  low_hit  = executing_i && at_low
                    && !low_preset_reached_flag_reg;
   wire  high_hit = executing_i && at_high
                    && !high_preset_reached_flag_reg;
   wire  und_hit  = prev_valid_reg && (prev_s >= unf_s)
                    && (cnt_s < unf_s);
   wire  ovf_hit  = prev_valid_reg && (prev_s <= ovf_s)
                    && (cnt_s > ovf_s);

   // ------------------------------------------------------------
   // interrupt requests after masking
   // ------------------------------------------------------------
   wire  low_req  = sub_en && low_hit && bidir_mode_i
                    && low_mask;
   wire  high_req = sub_en && high_hit && high_mask;
   wire  und_req  = sub_en && und_hit && bidir_mode_i
                    && und_mask;
   wire  ovf_req  = sub_en && ovf_hit;
   wire  [2:0] req_count = {2'b00, low_req} + {2'b00, high_req}
                         + {2'b00, und_req} + {2'b00, ovf_req};

   reg   [1:0] push_src;
   always @* begin
      if (ovf_req) begin
         push_src = `SRC_OVER;
      end else if (und_req) begin
         push_src = `SRC_UNDER;
      end else if (high_req) begin
         push_src = `SRC_HIGH;
      end else begin
         push_src = `SRC_LOW;
      end
   end

   wire  push      = (req_count != 3'd0);
   wire  extra_req = (req_count > 3'd1);

   // ------------------------------------------------------------
   // service queue: slot 0 is in service, slots 1 and 2 wait
   // ------------------------------------------------------------
   wire        pop       = service_done_i && (q_cnt_reg != 2'd0);
   wire [1:0]  cnt_after = q_cnt_reg - {1'b0, pop};
   wire        push_ok   = push && (cnt_after < 2'd3);
   wire        overrun   = (push && !push_ok) || extra_req;
   wire        head_new  = (pop && q_cnt_reg >= 2'd2)
                           || (push_ok && cnt_after == 2'd0);
   wire [1:0]  head_src  = (pop && q_cnt_reg >= 2'd2) ?
                           q_reg[1] : push_src;
   wire [3:0]  head_hot  = src_onehot(head_src);

   integer i;
   always @* begin
      for (i = 0; i < `QUEUE_SLOTS; i = i + 1) begin
         q_next[i] = q_reg[i];
      end
      if (pop) begin
         for (i = 0; i < `QUEUE_SLOTS - 1; i = i + 1) begin
            q_next[i] = q_reg[i+1];
         end
      end
      if (push_ok) begin
         q_next[cnt_after] = push_src;
      end
      q_cnt_next = cnt_after + {1'b0, push_ok};
   end

   genvar g;
   generate
      for (g = 0; g < `QUEUE_SLOTS; g = g + 1) begin : slot
         always @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               q_reg[g] <= 2'h0;
            end else begin
               q_reg[g] <= q_next[g];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // sequencing state and software registers
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_cnt_reg             <= 2'd0;
         prev_count_reg        <= {CW{1'b0}};
         prev_valid_reg        <= 1'b0;
         executing_reg         <= 1'b0;
         ctl_reg               <= `CTL_RESET;
         low_preset_value_reg  <= {CW{1'b0}};
         high_preset_value_reg <= {CW{1'b0}};
         underflow_limit_reg   <= {CW{1'b0}};
         overflow_limit_reg    <= {CW{1'b0}};
      end else begin
         q_cnt_reg      <= q_cnt_next;
         prev_count_reg <= count_total_i;
         prev_valid_reg <= 1'b1;
         executing_reg  <= executing_i;
         if (wr_i) begin
            case (addr_i)
               `OFS_CONTROL: begin
                  ctl_reg <= wdata_i[`CTL_WIDTH-1:0];
               end
               `OFS_LOW_PRESET: begin
                  low_preset_value_reg <= wdata_i[CW-1:0];
               end
               `OFS_HIGH_PRESET: begin
                  high_preset_value_reg <= wdata_i[CW-1:0];
               end
               `OFS_UNDER_LIMIT: begin
                  underflow_limit_reg <= wdata_i[CW-1:0];
               end
               `OFS_OVER_LIMIT: begin
                  overflow_limit_reg <= wdata_i[CW-1:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // status flags: hardware set wins over software clear
   // ------------------------------------------------------------
   wire  mode_entry = executing_i && !executing_reg;
   wire  sw_clr_lost = wr_status && !wdata_i[`ST_LOST];
   wire  sw_clr_lc   = wr_status && !wdata_i[`ST_LOW_CAUSE];
   wire  sw_clr_hc   = wr_status && !wdata_i[`ST_HIGH_CAUSE];
   wire  sw_clr_ue   = wr_status && !wdata_i[`ST_UNDER_EVENT];
   wire  sw_clr_uc   = wr_status && !wdata_i[`ST_UNDER_CAUSE];
   wire  sw_clr_oe   = wr_status && !wdata_i[`ST_OVER_EVENT];
   wire  start_low   = head_new && head_hot[`SRC_LOW];
   wire  start_high  = head_new && head_hot[`SRC_HIGH];
   wire  start_und   = head_new && head_hot[`SRC_UNDER];
   wire  start_ovf   = head_new && head_hot[`SRC_OVER];

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interrupt_lost_flag_reg      <= 1'b0;
      end else begin
         if (overrun) begin
            interrupt_lost_flag_reg <= 1'b1;
         end else if (sw_clr_lost) begin
            interrupt_lost_flag_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // reached flags follow the compare while executing
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_preset_reached_flag_reg  <= 1'b0;
         high_preset_reached_flag_reg <= 1'b0;
      end else begin
         if (executing_i) begin
            low_preset_reached_flag_reg  <= at_low;
            high_preset_reached_flag_reg <= at_high;
         end
      end
   end

   // ------------------------------------------------------------
   // cause flags: a starting source sets its own, clears the rest
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_preset_cause_flag_reg  <= 1'b0;
         high_preset_cause_flag_reg <= 1'b0;
         underflow_cause_flag_reg   <= 1'b0;
      end else begin
         if (start_low) begin
            low_preset_cause_flag_reg <= 1'b1;
         end else if (start_high || start_und || start_ovf
                      || mode_entry || sw_clr_lc) begin
            low_preset_cause_flag_reg <= 1'b0;
         end
         if (start_high) begin
            high_preset_cause_flag_reg <= 1'b1;
         end else if (start_low || start_und || start_ovf
                      || mode_entry || sw_clr_hc) begin
            high_preset_cause_flag_reg <= 1'b0;
         end
         if (start_und) begin
            underflow_cause_flag_reg <= 1'b1;
         end else if (start_low || start_high || start_ovf
                      || mode_entry || sw_clr_uc) begin
            underflow_cause_flag_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // event flags: set on a pass through a limit
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         underflow_event_flag_reg <= 1'b0;
         overflow_event_flag_reg  <= 1'b0;
      end else begin
         // flags only; no fault or halt path exists
         if (und_hit) begin
            underflow_event_flag_reg <= 1'b1;
         end else if (sw_clr_ue) begin
            underflow_event_flag_reg <= 1'b0;
         end
         if (ovf_hit) begin
            overflow_event_flag_reg <= 1'b1;
         end else if (sw_clr_oe) begin
            overflow_event_flag_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   wire [`ST_WIDTH-1:0] status_word = {
      overflow_event_flag_reg,
      underflow_cause_flag_reg,
      underflow_event_flag_reg,
      high_preset_reached_flag_reg,
      high_preset_cause_flag_reg,
      low_preset_reached_flag_reg,
      low_preset_cause_flag_reg,
      interrupt_lost_flag_reg,
      interrupt_pending_flag_o
   };

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= 32'h0000_0000;
         if (rd_i) begin
            case (addr_i)
               `OFS_CONTROL: begin
                  rdata_o[`CTL_WIDTH-1:0] <= ctl_reg;
               end
               `OFS_STATUS: begin
                  rdata_o[`ST_WIDTH-1:0] <= status_word;
               end
               `OFS_LOW_PRESET: begin
                  rdata_o[CW-1:0] <= low_preset_value_reg;
               end
               `OFS_HIGH_PRESET: begin
                  rdata_o[CW-1:0] <= high_preset_value_reg;
               end
               `OFS_UNDER_LIMIT: begin
                  rdata_o[CW-1:0] <= underflow_limit_reg;
               end
               `OFS_OVER_LIMIT: begin
                  rdata_o[CW-1:0] <= overflow_limit_reg;
               end
               `OFS_COUNT: begin
                  rdata_o[CW-1:0] <= count_total_i;
               end
               default: begin
                  rdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign service_active_o         = (q_cnt_reg != 2'd0);
   assign service_source_o         = q_reg[0];
   assign interrupt_pending_flag_o = (q_cnt_reg >= 2'd2);
   assign interrupt_lost_flag_o    = interrupt_lost_flag_reg;

endmodule

// ==== hdl/counter_flags_defines.vh ====
`ifndef COUNTER_FLAGS_DEFINES_VH
`define COUNTER_FLAGS_DEFINES_VH

// ---------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define OFS_CONTROL       8'h00
`define OFS_STATUS        8'h04
`define OFS_LOW_PRESET    8'h08
`define OFS_HIGH_PRESET   8'h0C
`define OFS_UNDER_LIMIT   8'h10
`define OFS_OVER_LIMIT    8'h14
`define OFS_COUNT         8'h18

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTL_SUB_ENABLE    0
`define CTL_LOW_MASK      1
`define CTL_HIGH_MASK     2
`define CTL_UNDER_MASK    3
`define CTL_WIDTH         4
`define CTL_RESET         4'h0

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ST_PENDING        0
`define ST_LOST           1
`define ST_LOW_CAUSE      2
`define ST_LOW_REACHED    3
`define ST_HIGH_CAUSE     4
`define ST_HIGH_REACHED   5
`define ST_UNDER_EVENT    6
`define ST_UNDER_CAUSE    7
`define ST_OVER_EVENT     8
`define ST_WIDTH          9

// ---------------------------------------------------------------
// interrupt source codes
// ---------------------------------------------------------------
`define SRC_LOW           2'h0
`define SRC_HIGH          2'h1
`define SRC_UNDER         2'h2
`define SRC_OVER          2'h3

// ---------------------------------------------------------------
// queue depth: one in service plus two waiting
// ---------------------------------------------------------------
`define QUEUE_SLOTS       3

`endif

// ==== verification/counter_flags_assertions.sv ====
`timescale 1ns/1ns
`include "counter_flags_defines.vh"

module counter_flags_assertions #(
   parameter CW = 32
) (
   input wire          mclk_i,
   input wire          rst_n_i,
   input wire [7:0]    addr_i,
   input wire [31:0]   wdata_i,
   input wire          wr_i,
   input wire          rd_i,
   input wire [31:0]   rdata_o,
   input wire [CW-1:0] count_total_i,
   input wire          executing_i,
   input wire          bidir_mode_i,
   input wire          service_done_i,
   input wire          service_active_o,
   input wire [1:0]    service_source_o,
   input wire          interrupt_pending_flag_o,
   input wire          interrupt_lost_flag_o
);
   // ------------------------------------------------------------
   // shadow of the control register
   // ------------------------------------------------------------
   reg [3:0] ctl_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         ctl_reg <= 4'h0;
      else if (wr_i && addr_i == `OFS_CONTROL)
         ctl_reg <= wdata_i[3:0];
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   property p_pend_active;
      interrupt_pending_flag_o |-> service_active_o;
   endproperty
   a_pend_active: assert property (p_pend_active)
      else $error("pending flag without active service");
   property p_pend_read;
      rd_i && addr_i == `OFS_STATUS
         |=> rdata_o[`ST_PENDING] == $past(interrupt_pending_flag_o);
   endproperty
   a_pend_read: assert property (p_pend_read)
      else $error("status read shows wrong pending bit");
   property p_lost_sticky;
      interrupt_lost_flag_o
         && !(wr_i && addr_i == `OFS_STATUS && !wdata_i[`ST_LOST])
         |=> interrupt_lost_flag_o;
   endproperty
   a_lost_sticky: assert property (p_lost_sticky)
      else $error("lost flag dropped without software clear");
   property p_lost_read;
      rd_i && addr_i == `OFS_STATUS
         |=> rdata_o[`ST_LOST] == $past(interrupt_lost_flag_o);
   endproperty
   a_lost_read: assert property (p_lost_read)
      else $error("status read shows wrong lost bit");
   property p_serve_hold;
      service_active_o && !service_done_i
         |=> service_active_o && $stable(service_source_o);
   endproperty
   a_serve_hold: assert property (p_serve_hold)
      else $error("service changed without done pulse");
   property p_sub_off;
      !service_active_o && !ctl_reg[`CTL_SUB_ENABLE] |=> !service_active_o;
   endproperty
   a_sub_off: assert property (p_sub_off)
      else $error("service started while subroutine disabled");
   property p_low_mask;
      $rose(service_active_o) |-> service_source_o != `SRC_LOW
         || ($past(ctl_reg[`CTL_LOW_MASK]) && $past(bidir_mode_i));
   endproperty
   a_low_mask: assert property (p_low_mask)
      else $error("low preset service while masked");
   property p_high_mask;
      $rose(service_active_o) |-> service_source_o != `SRC_HIGH
         || $past(ctl_reg[`CTL_HIGH_MASK]);
   endproperty
   a_high_mask: assert property (p_high_mask)
      else $error("high preset service while masked");
   property p_under_mask;
      $rose(service_active_o) |-> service_source_o != `SRC_UNDER
         || ($past(ctl_reg[`CTL_UNDER_MASK]) && $past(bidir_mode_i));
   endproperty
   a_under_mask: assert property (p_under_mask)
      else $error("underflow service while masked");
endmodule

bind counter_flags counter_flags_assertions #(.CW(CW)) i_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .count_total_i(count_total_i), .executing_i(executing_i),
   .bidir_mode_i(bidir_mode_i), .service_done_i(service_done_i),
   .service_active_o(service_active_o),
   .service_source_o(service_source_o),
   .interrupt_pending_flag_o(interrupt_pending_flag_o),
   .interrupt_lost_flag_o(interrupt_lost_flag_o));

// ==== verification/counter_flags_bench.sv ====
`timescale 1ns/1ns
`include "counter_flags_defines.vh"

module counter_flags_bench;
   localparam [31:0] dn_cross = 32'hFFFF_FF9B;
   localparam [31:0] up_cross = 32'h0000_0065;
   reg         mclk_i;
   reg         rst_n_i;
   reg  [7:0]  addr_i;
   reg  [31:0] wdata_i;
   reg         wr_i;
   reg         rd_i;
   wire [31:0] rdata_o;
   reg  [31:0] count_total_i;
   reg         executing_i;
   reg         bidir_mode_i;
   reg         service_done_i;
   wire        service_active_o;
   wire [1:0]  service_source_o;
   wire        interrupt_pending_flag_o;
   wire        interrupt_lost_flag_o;
   integer     err_count;
   integer     comparisons;
   integer     i;
   reg  [31:0] rd_val;

   counter_flags #(.CW(32)) i_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .count_total_i(count_total_i), .executing_i(executing_i),
      .bidir_mode_i(bidir_mode_i), .service_done_i(service_done_i),
      .service_active_o(service_active_o),
      .service_source_o(service_source_o),
      .interrupt_pending_flag_o(interrupt_pending_flag_o),
      .interrupt_lost_flag_o(interrupt_lost_flag_o));

   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // ------------------------------------------------------------
   // bus and service tasks
   // ------------------------------------------------------------
   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk_i);
      end
   endtask
   task reg_wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge mclk_i);
         wr_i <= 1'b0;
      end
   endtask
   task reg_rd(input [7:0] a);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge mclk_i);
         rd_i <= 1'b0;
         @(negedge mclk_i);
         rd_val = rdata_o;
      end
   endtask
   task done_pulse;
      begin
         @(posedge mclk_i);
         service_done_i <= 1'b1;
         @(posedge mclk_i);
         service_done_i <= 1'b0;
         @(negedge mclk_i);
      end
   endtask
   // one count step from zero to cb, then service and status checks
   task ev(input [3:0] ctl, input ex, input bd, input clr, input [31:0] cb,
           input act, input [1:0] src, input [8:0] st);
      begin
         reg_wr(`OFS_CONTROL, {28'h0, ctl});
         if (clr)
            reg_wr(`OFS_STATUS, 32'h0);
         executing_i <= ex;
         bidir_mode_i <= bd;
         count_total_i <= 32'h0;
         tick(3);
         count_total_i <= cb;
         tick(3);
         @(negedge mclk_i);
         check({31'h0, service_active_o}, {31'h0, act});
         if (act)
            check({30'h0, service_source_o}, {30'h0, src});
         reg_rd(`OFS_STATUS);
         check(rd_val, {23'h0, st});
         if (act)
            done_pulse;
      end
   endtask
   task give_verdict;
      begin
         $display("mismatches %0d comparisons %0d", err_count, comparisons);
         if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      repeat (4000) @(posedge mclk_i);
      err_count = err_count + 1;
      give_verdict;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      err_count = 0;
      comparisons = 0;
      rst_n_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      count_total_i = 32'h0;
      executing_i = 1'b0;
      bidir_mode_i = 1'b0;
      service_done_i = 1'b0;
      tick(16);
      rst_n_i <= 1'b1;
      reg_rd(`OFS_CONTROL);
      check(rd_val, 32'h0);
      reg_rd(`OFS_STATUS);
      check(rd_val, 32'h0);
      reg_rd(8'hFC);
      check(rd_val, 32'h0);
      reg_wr(`OFS_LOW_PRESET, 32'hFFFF_FFCE);
      reg_wr(`OFS_HIGH_PRESET, 32'h0000_0032);
      reg_wr(`OFS_UNDER_LIMIT, 32'hFFFF_FF9C);
      reg_wr(`OFS_OVER_LIMIT, 32'h0000_0064);
      reg_rd(`OFS_LOW_PRESET);
      check(rd_val, 32'hFFFF_FFCE);
      ev(4'h0, 0, 1, 1, up_cross, 0, 0, 9'h100);
      ev(4'hF, 0, 1, 1, up_cross, 1, 3, 9'h100);
      ev(4'h7, 0, 1, 1, dn_cross, 0, 0, 9'h040);
      ev(4'hF, 0, 0, 1, dn_cross, 0, 0, 9'h040);
      ev(4'h9, 0, 1, 1, dn_cross, 1, 2, 9'h0C0);
      ev(4'hD, 1, 1, 1, 32'hFFFF_FFCE, 0, 0, 9'h008);
      ev(4'hB, 1, 1, 1, 32'h0000_0032, 0, 0, 9'h020);
      ev(4'h3, 1, 1, 1, 32'hFFFF_FFCE, 1, 0, 9'h00C);
      ev(4'h5, 1, 1, 0, 32'h0000_0032, 1, 1, 9'h030);
      tick(1);
      executing_i <= 1'b0;
      tick(2);
      executing_i <= 1'b1;
      tick(2);
      reg_rd(`OFS_STATUS);
      check(rd_val, 32'h020);
      // queue: one underflow then three overflows, the last is lost
      reg_wr(`OFS_CONTROL, 32'h9);
      reg_wr(`OFS_STATUS, 32'h0);
      executing_i <= 1'b0;
      count_total_i <= dn_cross;
      for (i = 0; i < 3; i = i + 1) begin
         tick(2);
         count_total_i <= 32'h0;
         tick(2);
         count_total_i <= up_cross;
         tick(2);
         @(negedge mclk_i);
         check({31'h0, interrupt_pending_flag_o}, 32'h1);
         check({31'h0, interrupt_lost_flag_o}, {31'h0, i == 2});
      end
      check({30'h0, service_source_o}, {30'h0, `SRC_UNDER});
      reg_rd(`OFS_STATUS);
      check({31'h0, rd_val[7]}, 32'h1);
      done_pulse;
      check({30'h0, service_source_o}, {30'h0, `SRC_OVER});
      check({31'h0, interrupt_pending_flag_o}, 32'h1);
      reg_rd(`OFS_STATUS);
      check({30'h0, rd_val[7:6]}, 32'h1);
      done_pulse;
      check({31'h0, interrupt_pending_flag_o}, 32'h0);
      check({31'h0, service_active_o}, 32'h1);
      done_pulse;
      check({31'h0, service_active_o}, 32'h0);
      check({31'h0, interrupt_lost_flag_o}, 32'h1);
      reg_wr(`OFS_STATUS, 32'hFFFF_FFFD);
      @(negedge mclk_i);
      check({31'h0, interrupt_lost_flag_o}, 32'h0);
      reg_rd(`OFS_STATUS);
      check({31'h0, rd_val[8]}, 32'h1);
      reg_rd(`OFS_CONTROL);
      check(rd_val, 32'h9);
      reg_wr(`OFS_COUNT, 32'h0000_0000);
      reg_rd(`OFS_COUNT);
      check(rd_val, up_cross);
      give_verdict;
   end
endmodule
